// ==== src/rxs_pkg.sv ====
// shared constants and types of the receiver configuration block
package rxs_pkg;
    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_RX_BW = 6'h10;
    localparam logic [5:0] IDX_CENTRE = 6'h11;
    localparam logic [5:0] IDX_SYNC_CTL = 6'h12;
    localparam logic [5:0] IDX_RSVD = 6'h13;
    localparam logic [5:0] IDX_STRENGTH = 6'h14;
    localparam logic [5:0] IDX_ONOFF = 6'h15;
    localparam logic [5:0] IDX_PAT3 = 6'h16;
    localparam logic [5:0] IDX_PAT0 = 6'h19;
    localparam logic [5:0] IDX_FILL_CTL = 6'h20;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_RX_BW = 8'ha3;
    localparam logic [7:0] RST_CENTRE = 8'h38;
    localparam logic [7:0] RST_SYNC_CTL = 8'h18;
    localparam logic [7:0] RST_RSVD = 8'h07;
    localparam logic [7:0] RST_ONOFF = 8'h00;
    localparam logic [7:0] RST_PAT = 8'h00;
    localparam logic [2:0] RST_FILL_CTL = 3'h0;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_POLY_EN = 7;
    localparam int POS_BITSYNC_OFF = 6;
    localparam int POS_SYNC_EN = 5;
    localparam int POS_SYNC_SIZE = 3;
    localparam int POS_SYNC_TOL = 1;
    localparam int POS_STEP = 5;
    localparam int POS_DECAY = 2;
    localparam int POS_FILL_METHOD = 0;
    localparam int POS_CONT_MODE = 1;
    localparam int POS_FILL_MANUAL = 2;
    localparam int POS_FILL_CLEAR = 3;
    localparam int POS_FILL_STATUS = 4;
    localparam int SYNC_MAX_BITS = 32;
    // ------------------------------------------------------------
    // decoded configuration handed to the analog front end
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] lowpass_bw_code;
        logic [9:0] lowpass_bw_khz;
        logic [3:0] rx_bandwidth_code;
        logic [3:0] polyphase_centre_code;
        logic polyphase_enable;
        logic bitsync_bypass;
        logic [3:0] onoff_threshold_step;   // half dB units
        logic onoff_decay_per_chip;         // 1: several per chip
        logic [2:0] onoff_decay_log2;
        logic [1:0] onoff_average_cutoff;
    } rxs_cfg_t;
endpackage : rxs_pkg

// ==== src/rxs_rx_config.sv ====
// receiver configuration registers with sync word recognition
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
// Contract
// - lowpass code maps to sixteen bandwidths, reset 1010
// - receiver bandwidth code, reset 0011
// - polyphase centre code, reset 0011
// - polyphase filter only when enabled, reset off
// - bit synchronizer bypassed when disable bit set in continuous mode only
// - sync recognition only while enabled
// - sync size code selects 8 to 32 bits
// - tolerance code allows zero to three errors
// - four pattern bytes, leading bytes used by size
// - signal strength read only, half dB steps
// - threshold step code, 0.5 to 6 dB
// - threshold decay rate code
// - average cutoff codes 00 or 11 only
// - auto fill starts on sync when method 0
module rxs_rx_config
    import rxs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic demod_bit,
    input wire logic bitsync_clk,
    input wire logic [7:0] strength_in,
    output rxs_cfg_t rx_cfg,
    output logic rx_data_out,
    output logic rx_data_strobe,
    output logic sync_detect,
    output logic fifo_fill_active,
    output logic fifo_fill_start
);
    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] bw_reg, centre_reg, syncctl_reg, rsvd_reg, onoff_reg;
    logic [7:0] pat_reg [4];
    logic [2:0] fillctl_reg;
    logic fill_reg, fill_next;
    logic [31:0] prdata_reg, rd_mux;
    rxs_cfg_t cfg_reg, cfg_next;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire [5:0] idx = paddr[7:2];
    wire aligned = (paddr[1:0] == 2'b00) && ((paddr >> 8) == '0);
    wire is_pat = (idx >= IDX_PAT3) && (idx <= IDX_PAT0);
    wire hit = aligned && (is_pat || (idx >= IDX_RX_BW
        && idx <= IDX_ONOFF) || idx == IDX_FILL_CTL);
    wire access = psel && penable;
    wire wr_en = access && pwrite && hit;
    wire [1:0] pat_sel = 2'(idx - IDX_PAT3);
    wire [7:0] wbyte = pwdata[7:0];

    // zero wait state; errors only on unmapped addresses
    assign pready = 1'b1;
    assign pslverr = access && !hit;
    assign prdata = prdata_reg;

    // ------------------------------------------------------------
    // synchronisers for pins from the demodulator
    // ------------------------------------------------------------
    logic data_s1, data_s2, dclk_s1, dclk_s2, dclk_prev;
    logic [7:0] str_s1, str_s2, str_s3, str_hold;

    // strength bits may cross in different cycles; the held copy only
    // takes a word that stood unchanged for two samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_s1 <= 1'b0;
            data_s2 <= 1'b0;
            dclk_s1 <= 1'b0;
            dclk_s2 <= 1'b0;
            dclk_prev <= 1'b0;
            str_s1 <= 8'h00;
            str_s2 <= 8'h00;
            str_s3 <= 8'h00;
            str_hold <= 8'h00;
        end else begin
            data_s1 <= demod_bit;
            data_s2 <= data_s1;
            dclk_s1 <= bitsync_clk;
            dclk_s2 <= dclk_s1;
            dclk_prev <= dclk_s2;
            str_s1 <= strength_in;
            str_s2 <= str_s1;
            str_s3 <= str_s2;
            if (str_s3 == str_s2) str_hold <= str_s2;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // the strength index has no storage, so writes vanish
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bw_reg <= RST_RX_BW;
            centre_reg <= RST_CENTRE;
            syncctl_reg <= RST_SYNC_CTL;
            rsvd_reg <= RST_RSVD;
            onoff_reg <= RST_ONOFF;
            fillctl_reg <= RST_FILL_CTL;
        end else if (wr_en) begin
            if (idx == IDX_RX_BW) bw_reg <= wbyte;
            if (idx == IDX_CENTRE) centre_reg <= wbyte;
            if (idx == IDX_SYNC_CTL) syncctl_reg <= wbyte;
            if (idx == IDX_RSVD) rsvd_reg <= wbyte;
            if (idx == IDX_ONOFF) onoff_reg <= wbyte;
            if (idx == IDX_FILL_CTL) fillctl_reg <= wbyte[2:0];
        end
    end

    // pattern bytes, entry 0 holds the first byte on air
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) pat_reg[i] <= RST_PAT;
        end else if (wr_en && is_pat) begin
            pat_reg[pat_sel] <= wbyte;
        end
    end

    // ------------------------------------------------------------
    // read data, captured in the setup phase
    // ------------------------------------------------------------
    wire [7:0] fill_rd = {3'b000, fill_reg, 1'b0, fillctl_reg};
    wire [7:0] rd_byte =
        (idx == IDX_RX_BW) ? bw_reg :
        (idx == IDX_CENTRE) ? centre_reg :
        (idx == IDX_SYNC_CTL) ? syncctl_reg :
        (idx == IDX_RSVD) ? rsvd_reg :
        (idx == IDX_STRENGTH) ? str_hold :
        (idx == IDX_ONOFF) ? onoff_reg :
        is_pat ? pat_reg[pat_sel] :
        (idx == IDX_FILL_CTL) ? fill_rd : 8'h00;
    assign rd_mux = (hit && !pwrite) ? {24'h000000, rd_byte} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata_reg <= 32'h0;
        else if (psel && !penable) prdata_reg <= rd_mux;
    end

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    wire sync_en = syncctl_reg[POS_SYNC_EN];
    wire [1:0] sync_size = syncctl_reg[POS_SYNC_SIZE +: 2];
    wire [1:0] sync_tol = syncctl_reg[POS_SYNC_TOL +: 2];
    wire cont_mode = fillctl_reg[POS_CONT_MODE];
    wire fill_method = fillctl_reg[POS_FILL_METHOD];
    wire bitsync_bypass = cont_mode && syncctl_reg[POS_BITSYNC_OFF];
    wire [2:0] step = onoff_reg[POS_STEP +: 3];
    wire [2:0] decay = onoff_reg[POS_DECAY +: 3];

    // bandwidth table of the passive lowpass filter, in kHz
    function automatic logic [9:0] lp_khz(input logic [3:0] c);
        case (c)
            4'h0: lp_khz = 10'd65;
            4'h1: lp_khz = 10'd82;
            4'h2: lp_khz = 10'd109;
            4'h3: lp_khz = 10'd137;
            4'h4: lp_khz = 10'd157;
            4'h5: lp_khz = 10'd184;
            4'h6: lp_khz = 10'd211;
            4'h7: lp_khz = 10'd234;
            4'h8: lp_khz = 10'd262;
            4'h9: lp_khz = 10'd321;
            4'ha: lp_khz = 10'd378;
            4'hb: lp_khz = 10'd414;
            4'hc: lp_khz = 10'd458;
            4'hd: lp_khz = 10'd514;
            4'he: lp_khz = 10'd676;
            default: lp_khz = 10'd987;
        endcase
    endfunction : lp_khz

    // cutoffs scale with the crystal, so the analog side gets codes
    always_comb begin
        cfg_next.lowpass_bw_code = bw_reg[7:4];
        cfg_next.lowpass_bw_khz = lp_khz(bw_reg[7:4]);
        cfg_next.rx_bandwidth_code = bw_reg[3:0];
        cfg_next.polyphase_centre_code = centre_reg[7:4];
        cfg_next.polyphase_enable = syncctl_reg[POS_POLY_EN];
        cfg_next.bitsync_bypass = bitsync_bypass;
        // codes 0-3 step half dB, 4-7 step whole dB from 3 dB
        cfg_next.onoff_threshold_step = step[2] ?
            4'({step[1:0], 1'b0} + 4'd6) : 4'({1'b0, step} + 4'd1);
        cfg_next.onoff_decay_per_chip = decay[2];
        cfg_next.onoff_decay_log2 = decay[2] ?
            3'({1'b0, decay[1:0]} + 3'd1) : {1'b0, decay[1:0]};
        // reserved codes fall back to the default cutoff
        cfg_next.onoff_average_cutoff =
            (onoff_reg[1:0] == 2'b11) ? 2'b11 : 2'b00;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cfg_reg <= '0;
        else cfg_reg <= cfg_next;
    end
    assign rx_cfg = cfg_reg;

    // ------------------------------------------------------------
    // bit path and synchroniser bypass
    // ------------------------------------------------------------
    wire dclk_rise = dclk_s2 && !dclk_prev;
    wire bit_take = !bitsync_bypass && dclk_rise;
    logic data_reg, strobe_reg;

    // bypassed data has no bit timing, so no strobes then
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end else begin
            if (bitsync_bypass || bit_take) data_reg <= data_s2;
            strobe_reg <= bit_take;
        end
    end
    assign rx_data_out = data_reg;
    assign rx_data_strobe = strobe_reg;

    // ------------------------------------------------------------
    // sync word matcher
    // ------------------------------------------------------------
    logic [31:0] shift_reg;
    logic [5:0] cnt_reg;
    logic det_reg;
    wire [31:0] pattern = {pat_reg[0], pat_reg[1], pat_reg[2], pat_reg[3]};
    wire [4:0] drop = 5'({3'b000, ~sync_size} << 3);
    wire [31:0] want = pattern >> drop;
    wire [31:0] mask = 32'hffffffff >> drop;
    wire [31:0] diff = (shift_reg ^ want) & mask;
    wire [5:0] need = 6'({1'b0, sync_size, 3'b000} + 6'd8);

    function automatic logic [5:0] ones(input logic [31:0] v);
        ones = 6'd0;
        for (int i = 0; i < 32; i++) ones = ones + 6'(v[i]);
    endfunction : ones

    wire [5:0] errs = ones(diff);
    wire match = sync_en && strobe_reg && cnt_reg >= need
        && errs <= {4'b0000, sync_tol};

    // restart counting after a hit to avoid back-to-back detects
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg <= 32'h0;
            cnt_reg <= 6'd0;
            det_reg <= 1'b0;
        end else begin
            det_reg <= match;
            if (!sync_en || match) cnt_reg <= 6'd0;
            else if (bit_take && cnt_reg != 6'(SYNC_MAX_BITS))
                cnt_reg <= cnt_reg + 6'd1;
            if (bit_take) shift_reg <= {shift_reg[30:0], data_s2};
        end
    end
    assign sync_detect = det_reg;

    // ------------------------------------------------------------
    // fifo fill control
    // ------------------------------------------------------------
    wire clr_wr = wr_en && idx == IDX_FILL_CTL && wbyte[POS_FILL_CLEAR];
    wire auto_start = !fill_method && det_reg && !fill_reg;
    // a sync hit in the clearing cycle wins over the clear
    assign fill_next = fill_method ? fillctl_reg[POS_FILL_MANUAL] :
        (det_reg || (fill_reg && !clr_wr));

    logic start_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_reg <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            fill_reg <= fill_next;
            start_reg <= auto_start;
        end
    end
    assign fifo_fill_active = fill_reg;
    assign fifo_fill_start = start_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        access && !hit |-> pslverr) else $error("unmapped not flagged");
    a_strength_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && aligned && idx == IDX_STRENGTH
        |=> prdata == {24'h0, $past(str_hold)})
        else $error("strength read wrong");
    a_lowpass_map: assert property (
        @(posedge pclk) disable iff (!presetn)
        bw_reg[7:4] == 4'hf |=> rx_cfg.lowpass_bw_khz == 10'd987)
        else $error("lowpass table wrong");
    a_step_map: assert property (
        @(posedge pclk) disable iff (!presetn)
        step == 3'b111 |=> rx_cfg.onoff_threshold_step == 4'd12)
        else $error("step map wrong");
    a_cutoff_legal: assert property (
        @(posedge pclk) disable iff (!presetn)
        rx_cfg.onoff_average_cutoff inside {2'b00, 2'b11})
        else $error("reserved cutoff code");
    a_sync_off_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        !sync_en ##1 !sync_en |-> !sync_detect)
        else $error("detect while disabled");
    a_detect_tol: assert property (
        @(posedge pclk) disable iff (!presetn)
        strobe_reg && sync_en && errs > {4'b0000, sync_tol}
        |=> !sync_detect) else $error("detect beyond tolerance");
    a_bypass_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        bitsync_bypass |=> !rx_data_strobe && rx_data_out == $past(data_s2))
        else $error("bypass path wrong");
    a_fill_auto: assert property (
        @(posedge pclk) disable iff (!presetn)
        !fill_method && sync_detect |=> fifo_fill_active)
        else $error("fill not started");
    a_size_need: assert property (
        @(posedge pclk) disable iff (!presetn)
        sync_detect |-> $past(cnt_reg) >= $past(need))
        else $error("detect with too few bits");

    // decoded fields follow their registers one cycle later
    a_bw_codes: assert property (
        @(posedge pclk) disable iff (!presetn)
        presetn |=> rx_cfg.rx_bandwidth_code == $past(bw_reg[3:0])
        && rx_cfg.polyphase_centre_code == $past(centre_reg[7:4]))
        else $error("bandwidth codes wrong");
    a_poly_follow: assert property (
        @(posedge pclk) disable iff (!presetn)
        presetn |=> rx_cfg.polyphase_enable
        == $past(syncctl_reg[POS_POLY_EN]))
        else $error("polyphase enable wrong");
    a_bypass_cfg: assert property (
        @(posedge pclk) disable iff (!presetn)
        presetn |=> rx_cfg.bitsync_bypass == $past(bitsync_bypass))
        else $error("bypass flag wrong");
    a_decay_map: assert property (
        @(posedge pclk) disable iff (!presetn)
        decay == 3'b111 |=> rx_cfg.onoff_decay_per_chip
        && rx_cfg.onoff_decay_log2 == 3'd4)
        else $error("decay map wrong");

    // bit path and matcher housekeeping
    a_strobe_data: assert property (
        @(posedge pclk) disable iff (!presetn)
        rx_data_strobe |-> rx_data_out == $past(data_s2))
        else $error("taken bit wrong");
    a_cnt_restart: assert property (
        @(posedge pclk) disable iff (!presetn)
        !sync_en |=> cnt_reg == 6'd0)
        else $error("bit count kept while disabled");

    // a start pulse always comes with the fill level
    a_fill_start: assert property (
        @(posedge pclk) disable iff (!presetn)
        fifo_fill_start |-> fifo_fill_active)
        else $error("start without fill");
endmodule : rxs_rx_config

// ==== testbench/rxs_bit_src.sv ====
// serial bit source standing in for the remote transmitter
`timescale 1ns/100ps
module rxs_bit_src (
    output logic demod_bit,
    output logic bitsync_clk
);
    // ------------------------------------------------------------
    // frame driver
    // ------------------------------------------------------------
    // clock parked low between frames, so no stray bit is taken
    initial begin
        demod_bit = 1'b0;
        bitsync_clk = 1'b0;
    end
    // msb first; 40 ns phases keep each level over four pclk periods
    task automatic send(input logic [31:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            demod_bit <= w[i];
            #40 bitsync_clk <= 1'b1;
            #40 bitsync_clk <= 1'b0;
        end
        demod_bit <= ~demod_bit; // released line must not echo last bit
    endtask : send
endmodule : rxs_bit_src

// ==== testbench/rxs_rx_config_tb.sv ====
// self-checking bench for the receiver configuration block
`timescale 1ns/100ps
module rxs_rx_config_tb import rxs_pkg::*;;
    // ------------------------------------------------------------
    // signals, counters and expectation tables
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, strength_in;
    logic [31:0] pwdata, prdata, rd;
    logic demod_bit, bitsync_clk, rx_data_out, rx_data_strobe, er;
    logic sync_detect, fifo_fill_active, fifo_fill_start;
    rxs_cfg_t rx_cfg;
    int error_cnt = 0;
    int n_compared = 0;
    int n_det = 0;
    int n_stb = 0;
    int n_fs = 0;
    int d0, s0, f0;
    localparam logic [31:0] PAT = 32'hd3915ac6;
    localparam int BW [16] = '{65, 82, 109, 137, 157, 184, 211, 234,
                               262, 321, 378, 414, 458, 514, 676, 987};
    localparam int HALF_DB [8] = '{1, 2, 3, 4, 6, 8, 10, 12};
    rxs_rx_config dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .demod_bit(demod_bit),
        .bitsync_clk(bitsync_clk), .strength_in(strength_in),
        .rx_cfg(rx_cfg), .rx_data_out(rx_data_out),
        .rx_data_strobe(rx_data_strobe), .sync_detect(sync_detect),
        .fifo_fill_active(fifo_fill_active),
        .fifo_fill_start(fifo_fill_start));
    rxs_bit_src src (.demod_bit(demod_bit), .bitsync_clk(bitsync_clk));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // pulse outputs are counted, so a missed or extra pulse shows
    always @(posedge pclk) begin
        if (sync_detect === 1'b1) n_det++;
        if (rx_data_strobe === 1'b1) n_stb++;
        if (fifo_fill_start === 1'b1) n_fs++;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic give_verdict();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    // one apb transfer; bounded wait on pready, ends at the access edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            error_cnt++;
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(rd, exp);
    endtask : chk
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    // fresh reset first: leftover bits must not help a later match
    task automatic sync_case(input logic [1:0] sz, input logic [1:0] tol,
                             input int e, input logic en);
        int n;
        logic [31:0] w;
        logic hit;
        n = 8 * (int'(sz) + 1);
        w = (PAT >> (32 - n)) ^ ((32'h1 << e) - 32'h1);
        hit = en && (e <= int'(tol));
        do_reset();
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'(8'h58 + 4 * i), {24'h0, PAT[31 - 8 * i -: 8]});
        end
        apb(1'b1, 8'h48, {24'h0, 2'b00, en, sz, tol, 1'b0});
        d0 = n_det;
        s0 = n_stb;
        f0 = n_fs;
        src.send(w, n);
        repeat (10) @(posedge pclk);
        cmp(32'(n_stb - s0), 32'(n));
        cmp({31'h0, rx_data_out}, {31'h0, w[0]});
        cmp(32'(n_fs - f0), {31'h0, hit});
        cmp(32'(n_det - d0), {31'h0, hit});
        cmp({31'h0, fifo_fill_active}, {31'h0, hit});
        apb(1'b0, 8'h80, 32'h0);
        cmp(rd & 32'h11, {27'h0, hit, 4'h0});
        apb(1'b1, 8'h80, 32'h8);
        chk(8'h80, 32'h0);
    endtask : sync_case
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        strength_in = 8'h00;
        do_reset();
        chk(8'h40, 32'ha3);
        chk(8'h44, 32'h38);
        chk(8'h48, 32'h18);
        chk(8'h4c, 32'h07);
        chk(8'h54, 32'h00);
        for (int i = 0; i < 4; i++) chk(8'(8'h58 + 4 * i), 32'h0);
        cmp(32'(rx_cfg.lowpass_bw_khz), 32'd378);
        cmp({31'h0, rx_cfg.polyphase_enable}, 32'h0);
        // both nibbles move in opposite directions to catch swaps
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, 8'h40, 32'(c * 16 + 15 - c));
            apb(1'b1, 8'h44, 32'(c * 16 + 8));
            #15;
            cmp(32'(rx_cfg.lowpass_bw_khz), 32'(BW[c]));
            cmp(32'(rx_cfg.lowpass_bw_code), 32'(c));
            cmp(32'(rx_cfg.rx_bandwidth_code), 32'(15 - c));
            cmp(32'(rx_cfg.polyphase_centre_code), 32'(c));
        end
        // only cutoff codes 00 and 11 are ever written
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, 8'h54, 32'(c * 36 + 3 * (c % 2)));
            #15;
            cmp(32'(rx_cfg.onoff_threshold_step), 32'(HALF_DB[c]));
            cmp(32'({rx_cfg.onoff_decay_per_chip, rx_cfg.onoff_decay_log2}),
                32'(c < 4 ? c : c + 5));
            cmp(32'(rx_cfg.onoff_average_cutoff), 32'(3 * (c % 2)));
            chk(8'h54, 32'(c * 36 + 3 * (c % 2)));
        end
        apb(1'b1, 8'h48, 32'h80);
        #15;
        cmp({31'h0, rx_cfg.polyphase_enable}, 32'h1);
        // strength is only ever read, never written
        @(posedge pclk);
        strength_in <= 8'h5a;
        repeat (4) @(posedge pclk);
        chk(8'h50, 32'h5a);
        chk(8'h6c, 32'h0);
        cmp({31'h0, er}, 32'h1);
        sync_case(2'b00, 2'b00, 0, 1'b1);
        sync_case(2'b01, 2'b01, 1, 1'b1);
        sync_case(2'b10, 2'b10, 3, 1'b1);
        sync_case(2'b11, 2'b11, 3, 1'b1);
        sync_case(2'b11, 2'b00, 1, 1'b1);
        sync_case(2'b11, 2'b00, 0, 1'b0);
        // continuous mode with the synchronizer off takes no bits
        do_reset();
        apb(1'b1, 8'h80, 32'h2);
        apb(1'b1, 8'h48, 32'h40);
        s0 = n_stb;
        src.send(32'ha5, 8);
        repeat (10) @(posedge pclk);
        cmp(32'(n_stb - s0), 32'h0);
        cmp({31'h0, rx_cfg.bitsync_bypass}, 32'h1);
        cmp({31'h0, rx_data_out}, 32'h0);
        give_verdict();
    end
endmodule : rxs_rx_config_tb
